// ==== pwm_pkg.sv ====
// Purpose: Constants shared by the three-phase reset-synchronized PWM block.
// Assumes: 20 MHz core clock, 16-bit register port with one-cycle read latency.
// Notes:   Offsets are byte addresses on the plain register port.
// Function
// - Counter clears on its final state equal to cycle; period is cycle plus one counts.
// - Counter advances once per divided clock; each count step lasts 100 ns.
// - Duty of zero still gives a one-count pulse every carrier cycle.
// - Duty at or above cycle toggles the phase only at each cycle end.
// - No duty value holds a PWM output constant at either level.
// - Cycle compare-match interrupt is raised exactly once per carrier cycle.
// - Positive output toggles on duty match and again on each counter clear.
// - With buffering on, buffers copy into cycle and duty on cycle match.
// - Each phase drives a second pin carrying the inverse of its positive output while running.
package pwm_pkg;

    // Widths of the datapath and of the register port.
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned PHASES = 3;

    // Clock rate and count step, and the derived divider length.
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned STEP_NS       = 100;
    localparam int unsigned STEP_CYCLES   = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DIV_W         = 4;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CYCLES - 1);

    // Register offsets.
    localparam logic [ADDR_W-1:0] CTRL_OFS      = 8'h00;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] IRQ_CLR_OFS   = 8'h08;
    localparam logic [ADDR_W-1:0] IRQ_EN_OFS    = 8'h0c;
    localparam logic [ADDR_W-1:0] CYC_BUF_OFS   = 8'h10;
    localparam logic [ADDR_W-1:0] DUTY_BUF_OFS  = 8'h14;
    localparam logic [ADDR_W-1:0] CYC_CMP_OFS   = 8'h20;
    localparam logic [ADDR_W-1:0] DUTY_CMP_OFS  = 8'h24;
    localparam logic [ADDR_W-1:0] COUNTER_OFS   = 8'h30;
    localparam logic [ADDR_W-1:0] REG_STRIDE    = 8'h04;

    // Control field positions.
    localparam int unsigned CTRL_RUN_BIT  = 0;
    localparam int unsigned CTRL_BUF_BIT  = 1;
    localparam int unsigned CTRL_TOG_BIT  = 2;
    localparam int unsigned CTRL_W        = 3;

    // Values after reset.
    localparam logic [CTRL_W-1:0] CTRL_RST   = 3'h0;
    localparam logic [DATA_W-1:0] CYCLE_RST  = 16'hffff;
    localparam logic [DATA_W-1:0] DUTY_RST   = 16'h0000;
    localparam logic [DATA_W-1:0] COUNT_RST  = 16'h0000;
    localparam logic [DATA_W-1:0] ZERO_WORD  = 16'h0000;

endpackage

// ==== pwm_phase.sv ====
// Purpose: One PWM phase: positive and inverse outputs from the shared counter.
// Assumes: step_i and clear_i are one-cycle pulses from the same clock domain.
// Notes:   Both outputs sit low while the timer is stopped.
`timescale 1ns/10ps
module pwm_phase
    import pwm_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              run_i,
    input  wire logic              step_i,
    input  wire logic              clear_i,
    input  wire logic [DATA_W-1:0] count_i,
    input  wire logic [DATA_W-1:0] duty_i,
    output logic                   pos_o,
    output logic                   neg_o
);

    logic pos_r;
    logic pos_nxt;
    logic neg_r;
    logic armed_r;
    logic armed_nxt;
    logic match;
    logic toggle;

    // Duty matches count only after the first cycle end since the start, so the
    // high time always runs from the clear to the match, whatever count the
    // counter held when the timer was started.
    assign armed_nxt = run_i & (armed_r | (step_i & clear_i));

    // A match is taken from the count held during the step, so a duty of zero
    // still leaves a one-count pulse after the clear; a clear that coincides
    // with a match toggles only once.
    assign match   = (count_i == duty_i);
    assign toggle  = step_i & (clear_i | (match & armed_r));
    assign pos_nxt = run_i ? (pos_r ^ toggle) : 1'b0;

    // Output registers; the inverse pin mirrors the positive one while running.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pos_r   <= 1'b0;
            neg_r   <= 1'b0;
            armed_r <= 1'b0;
        end
        else
        begin
            armed_r <= armed_nxt;
            pos_r <= pos_nxt;
            neg_r <= run_i & ~pos_nxt;
        end
    end

    assign pos_o = pos_r;
    assign neg_o = neg_r;

endmodule // pwm_phase

// ==== reset_sync_three_phase_pwm.sv ====
// Purpose: Three-phase reset-synchronized PWM generator with register port.
// Assumes: Single 20 MHz clock; register master follows one-cycle strobes.
// Notes:   Duty writes never give a constant output; use a port pin for that.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
module reset_sync_three_phase_pwm
    import pwm_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    output logic                   irq_o,
    output logic                   cycle_toggle_out_o,
    output logic                   phase1_pos_out_o,
    output logic                   phase1_neg_out_o,
    output logic                   phase2_pos_out_o,
    output logic                   phase2_neg_out_o,
    output logic                   phase3_pos_out_o,
    output logic                   phase3_neg_out_o
);

    // Reset synchroniser and its released copy.
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n;

    // Control and interrupt registers.
    logic [CTRL_W-1:0] ctrl_r;
    logic              irq_stat_r;
    logic              irq_en_r;

    // Counter, divider and compare registers.
    logic [DIV_W-1:0]  div_r;
    logic [DATA_W-1:0] shared_up_counter_r;
    logic [DATA_W-1:0] carrier_cycle_cmp_r;
    logic [DATA_W-1:0] carrier_cycle_buf_r;
    logic [DATA_W-1:0] duty_cmp_r [PHASES];
    logic [DATA_W-1:0] duty_buf_r [PHASES];
    logic              cycle_toggle_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    // Decoded strobes and timing events.
    logic              run;
    logic              buf_on;
    logic              step;
    logic              cycle_end;
    logic              wr_ctrl;
    logic              wr_clr;
    logic              wr_en;
    logic              wr_cyc;
    logic [PHASES-1:0] wr_duty;
    logic [PHASES-1:0] pos_out;
    logic [PHASES-1:0] neg_out;

    // Reset is taken asynchronously and released through two flip-flops.
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    assign rst_n = rst_sync_r;

    // Control fields and timing events.
    assign run       = ctrl_r[CTRL_RUN_BIT];
    assign buf_on    = ctrl_r[CTRL_BUF_BIT];
    assign step      = run & (div_r == DIV_LAST);
    assign cycle_end = step & (shared_up_counter_r == carrier_cycle_cmp_r);

    // Register write decode.
    assign wr_ctrl = reg_wr_i & (reg_addr_i == CTRL_OFS);
    assign wr_clr  = reg_wr_i & (reg_addr_i == IRQ_CLR_OFS);
    assign wr_en   = reg_wr_i & (reg_addr_i == IRQ_EN_OFS);
    assign wr_cyc  = reg_wr_i & (reg_addr_i == CYC_BUF_OFS);

    // Divider that turns the core clock into the count step.
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            div_r <= '0;
        else if (!run || step)
            div_r <= '0;
        else
            div_r <= div_r + 1'b1;
    end

    // Shared up-counter: clears on the final state equal to the cycle value.
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            shared_up_counter_r <= COUNT_RST;
        else if (cycle_end)
            shared_up_counter_r <= COUNT_RST;
        else if (step)
            shared_up_counter_r <= shared_up_counter_r + 1'b1;
    end

    // Cycle buffer and cycle compare; without buffering a write goes straight through.
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            carrier_cycle_buf_r <= CYCLE_RST;
            carrier_cycle_cmp_r <= CYCLE_RST;
        end
        else
        begin
            if (wr_cyc)
                carrier_cycle_buf_r <= reg_wdata_i;
            if (wr_cyc && !buf_on)
                carrier_cycle_cmp_r <= reg_wdata_i;
            else if (cycle_end && buf_on)
                carrier_cycle_cmp_r <= carrier_cycle_buf_r;
        end
    end

    // Per-phase duty buffer, duty compare and output stage.
    for (genvar p = 0; p < PHASES; p++)
    begin : g_phase
        assign wr_duty[p] = reg_wr_i
                          & (reg_addr_i == DUTY_BUF_OFS + ADDR_W'(p) * REG_STRIDE);

        always_ff @(posedge core_clk_i or negedge rst_n)
        begin
            if (!rst_n)
            begin
                duty_buf_r[p] <= DUTY_RST;
                duty_cmp_r[p] <= DUTY_RST;
            end
            else
            begin
                if (wr_duty[p])
                    duty_buf_r[p] <= reg_wdata_i;
                if (wr_duty[p] && !buf_on)
                    duty_cmp_r[p] <= reg_wdata_i;
                else if (cycle_end && buf_on)
                    duty_cmp_r[p] <= duty_buf_r[p];
            end
        end

        pwm_phase u_phase (
            .clk_i   (core_clk_i),
            .rst_n_i (rst_n),
            .run_i   (run),
            .step_i  (step),
            .clear_i (cycle_end),
            .count_i (shared_up_counter_r),
            .duty_i  (duty_cmp_r[p]),
            .pos_o   (pos_out[p]),
            .neg_o   (neg_out[p])
        );
    end

    // Control, interrupt enable, sticky status and the cycle toggle pin.
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r         <= CTRL_RST;
            irq_en_r       <= 1'b0;
            irq_stat_r     <= 1'b0;
            cycle_toggle_r <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= reg_wdata_i[CTRL_W-1:0];
            if (wr_en)
                irq_en_r <= reg_wdata_i[0];
            if (cycle_end)
                irq_stat_r <= 1'b1;
            else if (wr_clr && reg_wdata_i[0])
                irq_stat_r <= 1'b0;
            if (cycle_end && ctrl_r[CTRL_TOG_BIT])
                cycle_toggle_r <= ~cycle_toggle_r;
        end
    end

    // Read data selection; unmapped and write-only offsets read as zero.
    always_comb
    begin
        rdata_nxt = ZERO_WORD;
        case (reg_addr_i)
            CTRL_OFS:                   rdata_nxt = {13'h0000, ctrl_r};
            IRQ_STAT_OFS:               rdata_nxt = {15'h0000, irq_stat_r};
            IRQ_EN_OFS:                 rdata_nxt = {15'h0000, irq_en_r};
            CYC_BUF_OFS:                rdata_nxt = carrier_cycle_buf_r;
            DUTY_BUF_OFS:               rdata_nxt = duty_buf_r[0];
            DUTY_BUF_OFS + 8'h04:       rdata_nxt = duty_buf_r[1];
            DUTY_BUF_OFS + 8'h08:       rdata_nxt = duty_buf_r[2];
            CYC_CMP_OFS:                rdata_nxt = carrier_cycle_cmp_r;
            DUTY_CMP_OFS:               rdata_nxt = duty_cmp_r[0];
            DUTY_CMP_OFS + 8'h04:       rdata_nxt = duty_cmp_r[1];
            DUTY_CMP_OFS + 8'h08:       rdata_nxt = duty_cmp_r[2];
            COUNTER_OFS:                rdata_nxt = shared_up_counter_r;
            default:                    rdata_nxt = ZERO_WORD;
        endcase
    end

    // Read data register: valid only in the cycle after the read strobe.
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= ZERO_WORD;
        else if (reg_rd_i)
            rdata_r <= rdata_nxt;
        else
            rdata_r <= ZERO_WORD;
    end

    // Outputs.
    assign reg_rdata_o        = rdata_r;
    assign irq_o              = irq_stat_r & irq_en_r;
    assign cycle_toggle_out_o = cycle_toggle_r;
    assign phase1_pos_out_o   = pos_out[0];
    assign phase1_neg_out_o   = neg_out[0];
    assign phase2_pos_out_o   = pos_out[1];
    assign phase2_neg_out_o   = neg_out[1];
    assign phase3_pos_out_o   = pos_out[2];
    assign phase3_neg_out_o   = neg_out[2];

endmodule // reset_sync_three_phase_pwm

// ==== pwm_asserts.sv ====
// Purpose: Port-level checks for the three-phase PWM block.
// Assumes: Cycle setting stays at 3 or more while the toggle pin is on.
// Notes:   Attached by bind from the bench top file.
`timescale 1ns/10ps
module pwm_asserts
    import pwm_pkg::*;
(
    input wire logic              core_clk_i,
    input wire logic              rst_n_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic              reg_wr_i,
    input wire logic              reg_rd_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic              irq_o,
    input wire logic              cycle_toggle_out_o,
    input wire logic              phase1_pos_out_o,
    input wire logic              phase1_neg_out_o,
    input wire logic              phase2_pos_out_o,
    input wire logic              phase2_neg_out_o,
    input wire logic              phase3_pos_out_o,
    input wire logic              phase3_neg_out_o
);
    // Every check runs on the core clock and rests during reset.
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // A carrier cycle end shows as a change on the toggle pin.
    sequence s_cyc_end;
        $changed(cycle_toggle_out_o);
    endsequence

    // Read data only stand in the cycle after a read strobe.
    property p_rd_idle;
        !reg_rd_i |=> reg_rdata_o == ZERO_WORD;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    // The clear register and places above the counter read as zero.
    property p_rd_none;
        reg_rd_i && (reg_addr_i == IRQ_CLR_OFS || reg_addr_i > COUNTER_OFS)
            |=> reg_rdata_o == ZERO_WORD;
    endproperty
    a_rd_none: assert property (p_rd_none) else $error("nonzero read of empty place");
    // Clearing the enable drops the interrupt in the next cycle.
    property p_irq_mask;
        reg_wr_i && reg_addr_i == IRQ_EN_OFS && !reg_wdata_i[0] |=> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq stayed up when masked");
    // A raised interrupt is backed by the sticky status bit.
    property p_stat_irq;
        irq_o && reg_rd_i && reg_addr_i == IRQ_STAT_OFS |=> reg_rdata_o[0];
    endproperty
    a_stat_irq: assert property (p_stat_irq) else $error("irq without status bit");
    // Every cycle end toggles all three positive outputs.
    property p_cyc_all;
        s_cyc_end |-> $changed(phase1_pos_out_o) && $changed(phase2_pos_out_o)
            && $changed(phase3_pos_out_o);
    endproperty
    a_cyc_all: assert property (p_cyc_all) else $error("phase missed cycle end");
    // Cycle ends are at least three counts apart for cycle settings of 3 or more.
    property p_cyc_gap;
        s_cyc_end |=> $stable(cycle_toggle_out_o)[*5];
    endproperty
    a_cyc_gap: assert property (p_cyc_gap) else $error("cycle end too soon");
    // The inverse pin falls whenever its positive pin rises.
    property p_inv1;
        $rose(phase1_pos_out_o) |-> $fell(phase1_neg_out_o);
    endproperty
    a_inv1: assert property (p_inv1) else $error("phase 1 inverse wrong");
    property p_inv2;
        $rose(phase2_pos_out_o) |-> $fell(phase2_neg_out_o);
    endproperty
    a_inv2: assert property (p_inv2) else $error("phase 2 inverse wrong");
    property p_inv3;
        $rose(phase3_pos_out_o) |-> $fell(phase3_neg_out_o);
    endproperty
    a_inv3: assert property (p_inv3) else $error("phase 3 inverse wrong");
    // No phase ever drives both of its pins high.
    property p_no_both;
        !(phase1_pos_out_o && phase1_neg_out_o) && !(phase2_pos_out_o && phase2_neg_out_o)
            && !(phase3_pos_out_o && phase3_neg_out_o);
    endproperty
    a_no_both: assert property (p_no_both) else $error("pos and neg both high");
endmodule // pwm_asserts

// ==== gate_drv_model.sv ====
// Purpose: Stand-in for the gate drivers on the six PWM pins.
// Assumes: Gate commands are active high.
// Notes:   Reports any phase whose two switches were on together.
`timescale 1ns/10ps
module gate_drv_model
(
    input  wire logic       clk_i,
    input  wire logic [2:0] hi_i,
    input  wire logic [2:0] lo_i,
    output logic      [2:0] shoot_o
);
    logic [2:0] shoot_r = 3'h0;

    // A fixed level would come from a port pin, never from the duty setting.
    always @(posedge clk_i)
        shoot_r <= shoot_r | (hi_i & lo_i);
    assign shoot_o = shoot_r;
endmodule // gate_drv_model

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the three-phase PWM block.
// Assumes: Cycle settings stay at 3 or more while the toggle pin runs.
// Notes:   Expected waveforms follow from the cycle and duty settings.
`timescale 1ns/10ps
module tb_top
    import pwm_pkg::*;
();
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              tog;
    logic [2:0]        pos;
    logic [2:0]        neg;
    logic [2:0]        shoot;
    int                fail_count = 0;
    int                tests_run = 0;
    int                cyc = 0;

    always #25 clk = ~clk;

    reset_sync_three_phase_pwm u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
        .cycle_toggle_out_o(tog), .phase1_pos_out_o(pos[0]), .phase1_neg_out_o(neg[0]),
        .phase2_pos_out_o(pos[1]), .phase2_neg_out_o(neg[1]), .phase3_pos_out_o(pos[2]),
        .phase3_neg_out_o(neg[2]));
    gate_drv_model u_gate (.clk_i(clk), .hi_i(pos), .lo_i(neg), .shoot_o(shoot));

    // Cuts a hung run short.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fail_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus tasks start just after an edge and leave one idle cycle behind them.
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    // Read data are taken mid-cycle, while they stand after the strobe.
    task automatic rd_get(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] d;
        rd_get(a, d);
        chk(d, e);
    endtask

    // Waits for a change on the toggle pin or for the interrupt to be high, bounded, and returns the time.
    task automatic wait_chg(input bit use_irq, output time t);
        logic v;
        int n;
        v = use_irq ? 1'b0 : tog;
        n = 0;
        while ((use_irq ? irq : tog) === v && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        t = $time;
    endtask

    task automatic t_reset();
        logic [ADDR_W-1:0] a[7] = '{CTRL_OFS, IRQ_STAT_OFS, IRQ_CLR_OFS, CYC_CMP_OFS,
            DUTY_CMP_OFS, COUNTER_OFS, 8'h40};
        logic [DATA_W-1:0] e[7] = '{16'h0000, 16'h0000, 16'h0000, CYCLE_RST, DUTY_RST,
            COUNT_RST, 16'h0000};
        foreach (a[i]) rd_chk(a[i], e[i]);
    endtask

    // Unbuffered writes land at once; the active compare is read-only.
    task automatic t_load();
        logic [DATA_W-1:0] d[3] = '{16'h0001, 16'h0000, 16'h0005};
        wr_reg(CYC_BUF_OFS, 16'h0003);
        wr_reg(CYC_CMP_OFS, 16'h0007);
        foreach (d[i]) wr_reg(ADDR_W'(DUTY_BUF_OFS + REG_STRIDE * i), d[i]);
        rd_chk(CYC_CMP_OFS, 16'h0003);
        foreach (d[i]) rd_chk(ADDR_W'(DUTY_CMP_OFS + REG_STRIDE * i), d[i]);
    endtask

    // Cycle 3 gives 8 clocks a period; high time is duty plus one counts, and duty 5 toggles once a period.
    task automatic t_wave();
        int hi[3] = '{0, 0, 0};
        time t0;
        time t1;
        wr_reg(CTRL_OFS, 16'h0005);
        repeat (40) @(posedge clk);
        repeat (16)
        begin
            @(posedge clk);
            foreach (hi[k]) hi[k] += int'(pos[k] === 1'b1 && neg[k] === 1'b0);
        end
        chk(16'(hi[0]), 16'h0008);
        chk(16'(hi[1]), 16'h0004);
        chk(16'(hi[2]), 16'h0008);
        wait_chg(1'b0, t0);
        wait_chg(1'b0, t1);
        chk(16'((t1 - t0) / 50), 16'h0008);
    endtask

    // The counter steps once in two clocks, so reads two clocks apart see one step.
    task automatic t_count();
        logic [DATA_W-1:0] c0;
        rd_get(COUNTER_OFS, c0);
        chk(c0 & 16'hfffc, 16'h0000);
        rd_chk(COUNTER_OFS, (c0 + 16'h0001) & 16'h0003);
    endtask

    task automatic t_irq();
        time t0;
        time t1;
        wr_reg(IRQ_EN_OFS, 16'h0001);
        wait_chg(1'b0, t0);
        wr_reg(IRQ_CLR_OFS, 16'h0001);
        wait_chg(1'b1, t0);
        wr_reg(IRQ_CLR_OFS, 16'h0001);
        wait_chg(1'b1, t1);
        chk(16'((t1 - t0) / 50), 16'h0008);
        rd_chk(IRQ_STAT_OFS, 16'h0001);
        wr_reg(IRQ_EN_OFS, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        rd_chk(IRQ_STAT_OFS, 16'h0001);
    endtask

    // Buffered values wait for the next cycle end.
    task automatic t_buf();
        time t0;
        time t1;
        wr_reg(CTRL_OFS, 16'h0007);
        wait_chg(1'b0, t0);
        wr_reg(CYC_BUF_OFS, 16'h0007);
        wr_reg(DUTY_BUF_OFS, 16'h0002);
        rd_chk(CYC_CMP_OFS, 16'h0003);
        wait_chg(1'b0, t0);
        wait_chg(1'b0, t1);
        chk(16'((t1 - t0) / 50), 16'h0010);
        rd_chk(DUTY_CMP_OFS, 16'h0002);
    endtask

    // Stopping freezes the counter and drops the outputs one clock after the write.
    task automatic t_stop();
        logic [DATA_W-1:0] c0;
        wr_reg(CTRL_OFS, 16'h0000);
        @(posedge clk);
        chk({10'h000, pos, neg}, 16'h0000);
        rd_get(COUNTER_OFS, c0);
        chk(c0 & 16'hfff8, 16'h0000);
        rd_chk(COUNTER_OFS, c0);
        chk({13'h0000, shoot}, 16'h0000);
    endtask

    // Main sequence.
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_load();
        t_wave();
        t_count();
        t_irq();
        t_buf();
        t_stop();
        conclude();
    end
endmodule // tb_top

bind reset_sync_three_phase_pwm pwm_asserts u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .cycle_toggle_out_o(cycle_toggle_out_o), .phase1_pos_out_o(phase1_pos_out_o),
    .phase1_neg_out_o(phase1_neg_out_o), .phase2_pos_out_o(phase2_pos_out_o),
    .phase2_neg_out_o(phase2_neg_out_o), .phase3_pos_out_o(phase3_pos_out_o),
    .phase3_neg_out_o(phase3_neg_out_o));
